// >>> rtl/ema_alu_regs.vh
// constants for the extended memory alu datapath
`ifndef EMA_ALU_REGS_VH
`define EMA_ALU_REGS_VH

// operation codes on op_code_in
`define EMA_OP_W                     5
`define EMA_OP_COMPLEMENT_MEM        5'h0_0
`define EMA_OP_COMPLEMENT_TO_ACC     5'h0_1
`define EMA_OP_DECIMAL_ADJUST_TO_MEM 5'h0_2
`define EMA_OP_DECREMENT_MEM         5'h0_3
`define EMA_OP_DECREMENT_TO_ACC      5'h0_4
`define EMA_OP_INCREMENT_MEM         5'h0_5
`define EMA_OP_INCREMENT_TO_ACC      5'h0_6
`define EMA_OP_MOVE_TO_ACC           5'h0_7
`define EMA_OP_MOVE_TO_MEM           5'h0_8
`define EMA_OP_OR_TO_ACC             5'h0_9
`define EMA_OP_OR_TO_MEM             5'h0_a
`define EMA_OP_ROTATE_LEFT_MEM       5'h0_b
`define EMA_OP_ROTATE_LEFT_TO_ACC    5'h0_c
`define EMA_OP_ROTATE_LEFT_CARRY_MEM 5'h0_d
`define EMA_OP_ROTATE_LEFT_CARRY_ACC 5'h0_e
`define EMA_OP_ROTATE_RIGHT_MEM      5'h0_f
`define EMA_OP_ROTATE_RIGHT_TO_ACC   5'h1_0
`define EMA_OP_ROT_RIGHT_CARRY_MEM   5'h1_1
`define EMA_OP_ROT_RIGHT_CARRY_ACC   5'h1_2
`define EMA_OP_SUB_BORROW_TO_ACC     5'h1_3
`define EMA_OP_SUB_BORROW_TO_MEM     5'h1_4

// status flag layout
`define EMA_FLAGS_W                  6
`define EMA_FLAG_CARRY               0
`define EMA_FLAG_AUX_CARRY           1
`define EMA_FLAG_ZERO                2
`define EMA_FLAG_OVERFLOW            3
`define EMA_FLAG_SIGNED_COMPARE      4
`define EMA_FLAG_COMBINED_ZERO       5
`define EMA_FLAGS_RESET              6'h0_0

// data values
`define EMA_BYTE_ZERO                8'h0_0
`define EMA_BYTE_ONE                 8'h0_1
`define EMA_ACC_RESET                8'h0_0
`define EMA_NIBBLE_MAX_BCD           4'h9
`define EMA_ADJ_NONE                 8'h0_0
`define EMA_ADJ_LOW                  8'h0_6
`define EMA_ADJ_HIGH                 8'h60
`define EMA_ADJ_BOTH                 8'h66

`endif

// >>> rtl/ema_alu.v
// extended memory operand alu datapath with accumulator and status flags
`timescale 1ns/1ps
`default_nettype none
`include "ema_alu_regs.vh"

module ema_alu #(
    parameter ADDR_W = 8
) (
    input  wire                    clock_in,         // core clock, 25 MHz
    input  wire                    rst_in,           // synchronous reset, high
    input  wire                    op_valid_in,      // start an operation
    input  wire [`EMA_OP_W-1:0]    op_code_in,       // operation select
    input  wire [ADDR_W-1:0]       op_addr_in,       // flat operand address
    input  wire [7:0]              mem_rdata_in,     // memory read data
    input  wire                    acc_load_in,      // core writes accumulator
    input  wire [7:0]              acc_load_data_in, // value for accumulator
    input  wire                    flags_load_in,    // core writes flags
    input  wire [`EMA_FLAGS_W-1:0] flags_load_data_in, // value for flags
    output reg  [7:0]              acc_out,          // accumulator
    output reg  [`EMA_FLAGS_W-1:0] flags_out,        // status flags
    output reg  [ADDR_W-1:0]       mem_addr_out,     // memory address
    output reg                     mem_rd_out,       // memory read strobe
    output reg                     mem_wr_out,       // memory write strobe
    output reg  [7:0]              mem_wdata_out,    // memory write data
    output reg                     busy_out,         // operation in flight
    output reg                     done_out          // operation finished
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_READ = 3'b010;
    localparam [2:0] ST_EXEC = 3'b100;

    reg [2:0]              state_q;
    reg [2:0]              state_d;
    reg [`EMA_OP_W-1:0]    op_q;
    reg [7:0]              acc_d;
    reg [`EMA_FLAGS_W-1:0] flags_d;
    reg [7:0]              result;
    reg                    to_mem;
    reg                    to_acc;

    // operand and flag shorthands
    wire [7:0] m_val  = mem_rdata_in;
    wire [7:0] a_val  = acc_out;
    wire       c_old  = flags_out[`EMA_FLAG_CARRY];
    wire       ac_old = flags_out[`EMA_FLAG_AUX_CARRY];
    wire       z_old  = flags_out[`EMA_FLAG_ZERO];

    // subtract with borrow: a + ~m + c, carry out means no borrow
    wire [8:0] sub_full = {1'b0, a_val} + {1'b0, ~m_val} + {8'h0_0, c_old};
    wire [4:0] sub_low  = {1'b0, a_val[3:0]} + {1'b0, ~m_val[3:0]}
                          + {4'h0, c_old};
    wire [7:0] sub_res  = sub_full[7:0];
    // signed overflow only when operand signs differ
    wire       sub_ov   = (a_val[7] != m_val[7]) && (sub_res[7] != a_val[7]);

    // decimal adjust corrections chosen from the pre-adjust conditions
    wire       daa_lo   = (a_val[3:0] > `EMA_NIBBLE_MAX_BCD) || ac_old;
    wire       daa_hi   = (a_val[7:4] > `EMA_NIBBLE_MAX_BCD) || c_old;
    reg  [7:0] daa_adj;
    wire [8:0] daa_sum  = {1'b0, a_val} + {1'b0, daa_adj};

    always @* begin
        case ({daa_hi, daa_lo})
            2'b01: daa_adj = `EMA_ADJ_LOW;
            2'b10: daa_adj = `EMA_ADJ_HIGH;
            2'b11: daa_adj = `EMA_ADJ_BOTH;
            default: daa_adj = `EMA_ADJ_NONE;
        endcase
    end

    // fixed three-cycle walk; no stall input, memory must answer next cycle
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (op_valid_in) begin
                    state_d = ST_READ;
                end
            end

            ST_READ: begin
                state_d = ST_EXEC;
            end

            ST_EXEC: begin
                state_d = ST_IDLE;
            end

            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // operation datapath, evaluated while the read data is on mem_rdata_in
    always @* begin
        result  = m_val;
        to_mem  = 1'b0;
        to_acc  = 1'b0;
        flags_d = flags_out;
        case (op_q)
            `EMA_OP_COMPLEMENT_MEM: begin
                result = ~m_val;
                to_mem = 1'b1;
                flags_d[`EMA_FLAG_ZERO] = (result == `EMA_BYTE_ZERO);
            end

            `EMA_OP_COMPLEMENT_TO_ACC: begin
                result = ~m_val;
                to_acc = 1'b1;
                flags_d[`EMA_FLAG_ZERO] = (result == `EMA_BYTE_ZERO);
            end

            `EMA_OP_DECIMAL_ADJUST_TO_MEM: begin
                result = daa_sum[7:0];
                to_mem = 1'b1;
                // only carry moves; it also keeps a carry already set
                flags_d[`EMA_FLAG_CARRY] = daa_sum[8] | c_old;
            end

            `EMA_OP_DECREMENT_MEM,
            `EMA_OP_DECREMENT_TO_ACC: begin
                result = m_val - `EMA_BYTE_ONE;
                to_mem = (op_q == `EMA_OP_DECREMENT_MEM);
                to_acc = (op_q == `EMA_OP_DECREMENT_TO_ACC);
                flags_d[`EMA_FLAG_ZERO] = (result == `EMA_BYTE_ZERO);
            end

            `EMA_OP_INCREMENT_MEM,
            `EMA_OP_INCREMENT_TO_ACC: begin
                result = m_val + `EMA_BYTE_ONE;
                to_mem = (op_q == `EMA_OP_INCREMENT_MEM);
                to_acc = (op_q == `EMA_OP_INCREMENT_TO_ACC);
                flags_d[`EMA_FLAG_ZERO] = (result == `EMA_BYTE_ZERO);
            end

            `EMA_OP_MOVE_TO_ACC: begin
                result = m_val;
                to_acc = 1'b1;
            end

            `EMA_OP_MOVE_TO_MEM: begin
                result = a_val;
                to_mem = 1'b1;
            end

            `EMA_OP_OR_TO_ACC,
            `EMA_OP_OR_TO_MEM: begin
                result = a_val | m_val;
                to_mem = (op_q == `EMA_OP_OR_TO_MEM);
                to_acc = (op_q == `EMA_OP_OR_TO_ACC);
                flags_d[`EMA_FLAG_ZERO] = (result == `EMA_BYTE_ZERO);
            end

            `EMA_OP_ROTATE_LEFT_MEM,
            `EMA_OP_ROTATE_LEFT_TO_ACC: begin
                result = {m_val[6:0], m_val[7]};
                to_mem = (op_q == `EMA_OP_ROTATE_LEFT_MEM);
                to_acc = (op_q == `EMA_OP_ROTATE_LEFT_TO_ACC);
            end

            `EMA_OP_ROTATE_LEFT_CARRY_MEM,
            `EMA_OP_ROTATE_LEFT_CARRY_ACC: begin
                result = {m_val[6:0], c_old};
                to_mem = (op_q == `EMA_OP_ROTATE_LEFT_CARRY_MEM);
                to_acc = (op_q == `EMA_OP_ROTATE_LEFT_CARRY_ACC);
                flags_d[`EMA_FLAG_CARRY] = m_val[7];
            end

            `EMA_OP_ROTATE_RIGHT_MEM,
            `EMA_OP_ROTATE_RIGHT_TO_ACC: begin
                result = {m_val[0], m_val[7:1]};
                to_mem = (op_q == `EMA_OP_ROTATE_RIGHT_MEM);
                to_acc = (op_q == `EMA_OP_ROTATE_RIGHT_TO_ACC);
            end

            `EMA_OP_ROT_RIGHT_CARRY_MEM,
            `EMA_OP_ROT_RIGHT_CARRY_ACC: begin
                result = {c_old, m_val[7:1]};
                to_mem = (op_q == `EMA_OP_ROT_RIGHT_CARRY_MEM);
                to_acc = (op_q == `EMA_OP_ROT_RIGHT_CARRY_ACC);
                flags_d[`EMA_FLAG_CARRY] = m_val[0];
            end

            `EMA_OP_SUB_BORROW_TO_ACC,
            `EMA_OP_SUB_BORROW_TO_MEM: begin
                result = sub_res;
                to_mem = (op_q == `EMA_OP_SUB_BORROW_TO_MEM);
                to_acc = (op_q == `EMA_OP_SUB_BORROW_TO_ACC);
                // carry high means no borrow, i.e. result not negative
                flags_d[`EMA_FLAG_CARRY]     = sub_full[8];
                flags_d[`EMA_FLAG_AUX_CARRY] = sub_low[4];
                flags_d[`EMA_FLAG_OVERFLOW]  = sub_ov;
                flags_d[`EMA_FLAG_ZERO]      =
                    (sub_res == `EMA_BYTE_ZERO);
                flags_d[`EMA_FLAG_SIGNED_COMPARE] =
                    sub_res[7] ^ sub_ov;
                // chains the zero test with the previous zero flag, so it spans a two-byte subtract
                flags_d[`EMA_FLAG_COMBINED_ZERO] =
                    (sub_res == `EMA_BYTE_ZERO) & z_old;
            end

            default: begin
                result = m_val;
            end
        endcase
    end

    // accumulator next value
    always @* begin
        acc_d = acc_out;
        if (state_q == ST_EXEC) begin
            if (to_acc) begin
                acc_d = result;
            end
        end else if (acc_load_in) begin
            // core loads in any state except ST_EXEC, so also while the read is in flight
            acc_d = acc_load_data_in;
        end
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            state_q       <= ST_IDLE;
            op_q          <= `EMA_OP_MOVE_TO_ACC;
            acc_out       <= `EMA_ACC_RESET;
            flags_out     <= `EMA_FLAGS_RESET;
            mem_addr_out  <= {ADDR_W{1'b0}};
            mem_rd_out    <= 1'b0;
            mem_wr_out    <= 1'b0;
            mem_wdata_out <= `EMA_BYTE_ZERO;
            busy_out      <= 1'b0;
            done_out      <= 1'b0;
        end else begin
            state_q    <= state_d;
            acc_out    <= acc_d;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            done_out   <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // flag loads are taken only in idle, dropped otherwise, so an operation never
                    // computes from a flag set changed under it
                    if (flags_load_in) begin
                        flags_out <= flags_load_data_in;
                    end
                    if (op_valid_in) begin
                        op_q         <= op_code_in;
                        // whole address used, no bank bits involved
                        mem_addr_out <= op_addr_in;
                        mem_rd_out   <= 1'b1;
                        busy_out     <= 1'b1;
                    end
                end

                ST_READ: begin
                    busy_out <= 1'b1;
                end

                // strobe and data leave together so memory sees one write
                ST_EXEC: begin
                    flags_out     <= flags_d;
                    mem_wr_out    <= to_mem;
                    mem_wdata_out <= result;
                    busy_out      <= 1'b0;
                    done_out      <= 1'b1;
                end

                default: begin
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> tb/ema_mem_model.sv
// data memory model answering the alu read and write strobes
`timescale 1ns/1ps
`default_nettype none
module ema_mem_model (
    input  wire logic       clock_in,  // core clock
    input  wire logic [7:0] addr_in,   // address from the alu
    input  wire logic       rd_in,     // read strobe
    input  wire logic       wr_in,     // write strobe
    input  wire logic [7:0] wdata_in,  // write data
    output var  logic [7:0] rdata_out  // read data, valid one cycle
);
    logic [7:0] mem [0:255];
    initial rdata_out = 8'h00;
    // data toggles outside its valid cycle so a late sample is caught
    always @(posedge clock_in) begin
        rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule
`default_nettype wire

// >>> tb/ema_alu_checker.sv
// port assertions for the extended alu datapath
`timescale 1ns/1ps
`default_nettype none
`include "ema_alu_regs.vh"
module ema_alu_checker #(
    parameter ADDR_W = 8
) (
    input wire logic              clock_in,      // core clock
    input wire logic              rst_in,        // reset
    input wire logic              op_valid_in,   // request
    input wire logic [4:0]        op_code_in,    // operation
    input wire logic [ADDR_W-1:0] op_addr_in,    // operand address
    input wire logic [7:0]        mem_rdata_in,  // read data
    input wire logic [7:0]        acc_out,       // accumulator
    input wire logic [5:0]        flags_out,     // flags
    input wire logic [ADDR_W-1:0] mem_addr_out,  // memory address
    input wire logic              mem_rd_out,    // read strobe
    input wire logic              mem_wr_out,    // write strobe
    input wire logic [7:0]        mem_wdata_out, // write data
    input wire logic              busy_out,      // busy
    input wire logic              done_out       // done
);
    logic [4:0] op_q;
    logic [7:0] rd_q;
    logic [7:0] acc_q;
    logic [5:0] fl_q;
    // one-cycle-old copies line up operands with the done cycle
    always @(posedge clock_in) begin
        rd_q <= mem_rdata_in;
        acc_q <= acc_out;
        fl_q <= flags_out;
        if (op_valid_in && !busy_out) begin
            op_q <= op_code_in;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence take_s;
        op_valid_in && !busy_out;
    endsequence
    sequence walk_s;
        mem_rd_out && busy_out ##1 busy_out && !mem_rd_out
            ##1 done_out && !busy_out;
    endsequence
    op_walk_a: assert property (take_s |=> walk_s)
        else $error("operation sequence wrong");
    flat_addr_a: assert property (take_s |=>
        mem_addr_out == $past(op_addr_in))
        else $error("address not passed through");
    cpl_mem_a: assert property (done_out &&
        op_q == `EMA_OP_COMPLEMENT_MEM |-> mem_wr_out &&
        mem_wdata_out == ~rd_q && flags_out[2] == (rd_q == 8'hff))
        else $error("complement to memory wrong");
    cpl_acc_a: assert property (done_out &&
        op_q == `EMA_OP_COMPLEMENT_TO_ACC |-> !mem_wr_out &&
        acc_out == ~rd_q)
        else $error("complement to acc wrong");
    inc_mem_a: assert property (done_out &&
        op_q == `EMA_OP_INCREMENT_MEM |-> mem_wr_out &&
        mem_wdata_out == rd_q + 8'h01)
        else $error("increment wrong");
    dec_acc_a: assert property (done_out &&
        op_q == `EMA_OP_DECREMENT_TO_ACC |-> acc_out == rd_q - 8'h01 &&
        flags_out[2] == (acc_out == 8'h00))
        else $error("decrement wrong");
    load_move_a: assert property (done_out &&
        op_q == `EMA_OP_MOVE_TO_ACC |-> acc_out == rd_q && flags_out == fl_q)
        else $error("load move wrong");
    store_move_a: assert property (done_out &&
        op_q == `EMA_OP_MOVE_TO_MEM |-> mem_wr_out &&
        mem_wdata_out == acc_q && flags_out == fl_q)
        else $error("store move wrong");
    rlc_acc_a: assert property (done_out &&
        op_q == `EMA_OP_ROTATE_LEFT_CARRY_ACC |->
        acc_out == {rd_q[6:0], fl_q[0]} && flags_out[0] == rd_q[7])
        else $error("rotate through carry wrong");
    sbc_acc_a: assert property (done_out &&
        op_q == `EMA_OP_SUB_BORROW_TO_ACC |->
        acc_out == acc_q - rd_q - {7'h00, ~fl_q[0]} &&
        flags_out[0] == ({1'b0, acc_q} >= {1'b0, rd_q} + {8'h00, ~fl_q[0]}))
        else $error("subtract with borrow wrong");
    daa_flags_a: assert property (done_out &&
        op_q == `EMA_OP_DECIMAL_ADJUST_TO_MEM |->
        flags_out[5:1] == fl_q[5:1] && acc_out == acc_q)
        else $error("decimal adjust touched flags");
endmodule
bind ema_alu ema_alu_checker #(.ADDR_W(ADDR_W)) u_chk (.clock_in, .rst_in,
    .op_valid_in, .op_code_in, .op_addr_in, .mem_rdata_in, .acc_out,
    .flags_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out,
    .busy_out, .done_out);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the extended alu datapath
`timescale 1ns/1ps
`default_nettype none
`include "ema_alu_regs.vh"
module tb_top;
    logic       clock_in, rst_in, op_valid_in, acc_load_in, flags_load_in;
    logic [4:0] op_code_in;
    logic [7:0] op_addr_in, mem_rdata_in, acc_load_data_in, acc_out;
    logic [7:0] mem_addr_out, mem_wdata_out;
    logic [5:0] flags_load_data_in, flags_out;
    logic       mem_rd_out, mem_wr_out, busy_out, done_out;
    int         fails, compares;
    ema_alu u_dut (.clock_in, .rst_in, .op_valid_in, .op_code_in,
        .op_addr_in, .mem_rdata_in, .acc_load_in, .acc_load_data_in,
        .flags_load_in, .flags_load_data_in, .acc_out, .flags_out,
        .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out,
        .busy_out, .done_out);
    ema_mem_model u_mem (.clock_in, .addr_in(mem_addr_out),
        .rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
        .rdata_out(mem_rdata_in));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task preset(input logic [7:0] a, input logic [5:0] f);
        @(posedge clock_in);
        acc_load_in <= 1'b1;
        acc_load_data_in <= a;
        flags_load_in <= 1'b1;
        flags_load_data_in <= f;
        @(posedge clock_in);
        acc_load_in <= 1'b0;
        flags_load_in <= 1'b0;
    endtask
    task run_op(input logic [4:0] op, input logic [7:0] a, m);
        int n;
        u_mem.mem[a] = m;
        @(posedge clock_in);
        op_valid_in <= 1'b1;
        op_code_in <= op;
        op_addr_in <= a;
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        n = 0;
        #1;
        while (done_out !== 1'b1) begin
            @(posedge clock_in);
            #1;
            n++;
            if (n > 8) begin
                fails++;
                finish_test;
            end
        end
    endtask
    // the memory write lands at the edge closing the done cycle
    task mem_after(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_in);
        #1;
        check(u_mem.mem[a], e);
    endtask
    task t_cpl;
        run_op(`EMA_OP_COMPLEMENT_MEM, 8'hff, 8'hff);
        check({7'h00, flags_out[`EMA_FLAG_ZERO]}, 8'h01);
        mem_after(8'hff, 8'h00);
        run_op(`EMA_OP_COMPLEMENT_TO_ACC, 8'h00, 8'h0f);
        check(acc_out, 8'hf0);
        mem_after(8'h00, 8'h0f);
    endtask
    task t_incdec;
        run_op(`EMA_OP_INCREMENT_MEM, 8'h41, 8'hff);
        check({7'h00, flags_out[`EMA_FLAG_ZERO]}, 8'h01);
        mem_after(8'h41, 8'h00);
        run_op(`EMA_OP_DECREMENT_TO_ACC, 8'h42, 8'h00);
        check(acc_out, 8'hff);
        check({7'h00, flags_out[`EMA_FLAG_ZERO]}, 8'h00);
        mem_after(8'h42, 8'h00);
        run_op(`EMA_OP_DECREMENT_MEM, 8'h43, 8'h01);
        mem_after(8'h43, 8'h00);
        run_op(`EMA_OP_INCREMENT_TO_ACC, 8'h44, 8'h7f);
        check(acc_out, 8'h80);
    endtask
    task t_move_or;
        preset(8'h5a, 6'h3f);
        run_op(`EMA_OP_MOVE_TO_ACC, 8'h10, 8'hc3);
        check({2'b00, flags_out}, 8'h3f);
        run_op(`EMA_OP_MOVE_TO_MEM, 8'h11, 8'h00);
        check({2'b00, flags_out}, 8'h3f);
        mem_after(8'h11, 8'hc3);
        preset(8'h00, 6'h00);
        run_op(`EMA_OP_OR_TO_ACC, 8'h12, 8'h00);
        check({acc_out[6:0], flags_out[`EMA_FLAG_ZERO]}, 8'h01);
        preset(8'h50, 6'h04);
        run_op(`EMA_OP_OR_TO_MEM, 8'h13, 8'h0a);
        check({7'h00, flags_out[`EMA_FLAG_ZERO]}, 8'h00);
        mem_after(8'h13, 8'h5a);
    endtask
    task t_rot;
        logic [4:0] ops [8] = '{`EMA_OP_ROTATE_LEFT_TO_ACC,
            `EMA_OP_ROTATE_LEFT_CARRY_ACC, `EMA_OP_ROTATE_RIGHT_TO_ACC,
            `EMA_OP_ROT_RIGHT_CARRY_ACC, `EMA_OP_ROTATE_LEFT_MEM,
            `EMA_OP_ROTATE_LEFT_CARRY_MEM, `EMA_OP_ROTATE_RIGHT_MEM,
            `EMA_OP_ROT_RIGHT_CARRY_MEM};
        logic [7:0] e [4] = '{8'h03, 8'h02, 8'hc0, 8'h40};
        logic [7:0] c [4] = '{8'h3e, 8'h3f, 8'h3e, 8'h3f};
        for (int i = 0; i < 8; i++) begin
            preset(8'h00, 6'h3e);
            run_op(ops[i], 8'h20, 8'h81);
            check({2'b00, flags_out}, c[i % 4]);
            if (i < 4) check(acc_out, e[i % 4]);
            else mem_after(8'h20, e[i % 4]);
        end
    endtask
    task t_daa;
        logic [7:0] av [3] = '{8'h3b, 8'ha0, 8'h12};
        logic [5:0] fv [3] = '{6'h00, 6'h3c, 6'h03};
        logic [7:0] rv [3] = '{8'h41, 8'h00, 8'h78};
        logic [7:0] fe [3] = '{8'h00, 8'h3d, 8'h03};
        for (int i = 0; i < 3; i++) begin
            preset(av[i], fv[i]);
            run_op(`EMA_OP_DECIMAL_ADJUST_TO_MEM, 8'h30, 8'h55);
            check({2'b00, flags_out}, fe[i]);
            mem_after(8'h30, rv[i]);
        end
    endtask
    task t_sbc;
        logic [7:0] av [4] = '{8'h10, 8'h05, 8'h05, 8'h80};
        logic [7:0] mv [4] = '{8'h20, 8'h05, 8'h04, 8'h01};
        logic [5:0] fv [4] = '{6'h01, 6'h00, 6'h04, 6'h01};
        logic [7:0] rv [4] = '{8'hf0, 8'hff, 8'h00, 8'h7f};
        logic [7:0] fe [4] = '{8'h12, 8'h10, 8'h27, 8'h19};
        for (int i = 0; i < 4; i++) begin
            preset(av[i], fv[i]);
            run_op(i[0] ? `EMA_OP_SUB_BORROW_TO_MEM
                        : `EMA_OP_SUB_BORROW_TO_ACC, 8'h7e, mv[i]);
            check({2'b00, flags_out}, fe[i]);
            if (!i[0]) check(acc_out, rv[i]);
            else mem_after(8'h7e, rv[i]);
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        {rst_in, op_valid_in, acc_load_in, flags_load_in} = 4'h8;
        {op_code_in, op_addr_in, acc_load_data_in} = 21'h0_0000;
        flags_load_data_in = 6'h00;
        fails = 0;
        compares = 0;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        t_cpl;
        t_incdec;
        t_move_or;
        t_rot;
        t_daa;
        t_sbc;
        finish_test;
    end
endmodule
`default_nettype wire
